// >>> prs_pkg.sv
// Package for the power-on-reset sequencer: timing constants, scheme codes,
// and the structs that carry supply status and line controls.
// Assumes a 10 MHz free-running oscillator clock.
package prs_pkg;

    // Oscillator rate
    localparam int unsigned CLK_HZ = 10_000_000;

    // Delay windows in microseconds (exclusive bounds)
    localparam int unsigned FAST_MIN_US = 3_000;
    localparam int unsigned FAST_MAX_US = 9_000;
    localparam int unsigned STD_MIN_US  = 50_000;
    localparam int unsigned STD_MAX_US  = 200_000;

    // Cycle counts derived from the rate; targets sit mid-window
    localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
    localparam int unsigned FAST_MIN_CYC = FAST_MIN_US * CYC_PER_US;
    localparam int unsigned FAST_MAX_CYC = FAST_MAX_US * CYC_PER_US;
    localparam int unsigned STD_MIN_CYC  = STD_MIN_US * CYC_PER_US;
    localparam int unsigned STD_MAX_CYC  = STD_MAX_US * CYC_PER_US;
    localparam int unsigned FAST_DEF_CYC = (FAST_MIN_CYC + FAST_MAX_CYC) / 2;
    localparam int unsigned STD_DEF_CYC  = (STD_MIN_CYC + STD_MAX_CYC) / 2;

    // Counter width, enough for the standard maximum
    localparam int unsigned CNT_W = 21;

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 21'h000000;

    // Scheme select pin width
    localparam int unsigned SEL_W = 4;

    // Scheme select codes; arbitrary encoding
    localparam logic [SEL_W-1:0] SEL_AS_STD  = 4'h0;
    localparam logic [SEL_W-1:0] SEL_AS_FAST = 4'h1;
    localparam logic [SEL_W-1:0] SEL_AP_STD  = 4'h2;
    localparam logic [SEL_W-1:0] SEL_AP_FAST = 4'h3;
    localparam logic [SEL_W-1:0] SEL_PS_STD  = 4'h4;
    localparam logic [SEL_W-1:0] SEL_PS_FAST = 4'h5;
    localparam logic [SEL_W-1:0] SEL_FPP     = 4'h6;

    // Decoded scheme
    typedef enum logic [2:0] {
        SCH_ACTIVE_SERIAL   = 3'h0,
        SCH_ACTIVE_PARALLEL = 3'h1,
        SCH_PASSIVE_SERIAL  = 3'h2,
        SCH_FAST_PASSIVE_PARALLEL = 3'h3,
        SCH_JTAG            = 3'h4,
        SCH_NONE            = 3'h5
    } prs_scheme_type;

    // Supply good flags from the analog trip detectors
    typedef struct packed {
        logic core_ok;
        logic pll_analog_ok;
        logic io_ok;
    } prs_supply_type;

    // Open-drain line control: drive value and enable (high drives the pin)
    typedef struct packed {
        logic o;
        logic oe;
    } prs_od_type;

endpackage

// >>> prs_delay_sel.sv
// Decoder from the scheme select pins to the delay length and scheme.
// Assumes the pins are static straps, synchronous to the oscillator.
`timescale 1ns/1ps
module prs_delay_sel (
    // Strap inputs
    input  wire logic [prs_pkg::SEL_W-1:0] scheme_select_pins,
    input  wire logic                      jtag_active,
    // Decoded outputs
    output logic                           fast_sel,
    output prs_pkg::prs_scheme_type        scheme
);

    // Delay class follows the pins even under the JTAG override
    always_comb begin
        fast_sel = 1'b0;
        scheme   = prs_pkg::SCH_NONE;
        unique case (scheme_select_pins)
            prs_pkg::SEL_AS_STD: begin
                scheme = prs_pkg::SCH_ACTIVE_SERIAL;
            end
            prs_pkg::SEL_AS_FAST: begin
                fast_sel = 1'b1;
                scheme   = prs_pkg::SCH_ACTIVE_SERIAL;
            end
            prs_pkg::SEL_AP_STD: begin
                scheme = prs_pkg::SCH_ACTIVE_PARALLEL;
            end
            prs_pkg::SEL_AP_FAST: begin
                fast_sel = 1'b1;
                scheme   = prs_pkg::SCH_ACTIVE_PARALLEL;
            end
            prs_pkg::SEL_PS_STD: begin
                scheme = prs_pkg::SCH_PASSIVE_SERIAL;
            end
            prs_pkg::SEL_PS_FAST: begin
                fast_sel = 1'b1;
                scheme   = prs_pkg::SCH_PASSIVE_SERIAL;
            end
            prs_pkg::SEL_FPP: begin
                fast_sel = 1'b1;
                scheme   = prs_pkg::SCH_FAST_PASSIVE_PARALLEL;
            end
            default: begin
                // Unused codes fall back to the safe, longer delay
                fast_sel = 1'b0;
                scheme   = prs_pkg::SCH_NONE;
            end
        endcase
        // JTAG overrides the scheme choice, not the delay class
        if (jtag_active) begin
            scheme = prs_pkg::SCH_JTAG;
        end
    end

endmodule // prs_delay_sel

// >>> prs_sequencer.sv
// Power-on-reset sequencer: holds the device in reset until supplies are
// good, counts the selected delay, then releases the status line.
// Assumes clk is the free-running internal oscillator and supply flags are
// synchronous to it. Status and done lines are open-drain with pull-ups.
// The host owns those pull-ups and the request line; this block only ever
// pulls a line low or lets it go.
//
// Overview of operation
// - Hold reset and keep status line low until all supplies pass trip point.
// - After power-up keep watching core and PLL analog supplies for brownout.
// - Pick fast or standard delay from the scheme select pins.
// - Fast delay lies strictly between 3 ms and 9 ms.
// - Standard delay lies strictly between 50 ms and 200 ms.
// - Fast-marked schemes use fast delay; standard-marked schemes use standard.
// - JTAG overrides the scheme choice; delay still follows the select pins.
// - During delay hold status and done low; afterwards release status, configure.
// - Device stays in reset while the request line or the status line is low.
`timescale 1ns/1ps
module prs_sequencer #(
    parameter int unsigned FAST_CYC = prs_pkg::FAST_DEF_CYC,
    parameter int unsigned STD_CYC  = prs_pkg::STD_DEF_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Supply monitors
    input  wire prs_pkg::prs_supply_type   supplies,
    // Strap and mode inputs
    input  wire logic [prs_pkg::SEL_W-1:0] scheme_select_pins,
    input  wire logic                      jtag_active,
    // Configuration lines
    input  wire logic                      config_req_n,
    input  wire logic                      status_n_in,
    output prs_pkg::prs_od_type            status_n_drv,
    output prs_pkg::prs_od_type            conf_done_drv,
    input  wire logic                      conf_done_seen,
    // Device state
    output logic                           por_active,
    output logic                           device_reset,
    output logic                           config_mode,
    output logic                           fast_delay,
    output prs_pkg::prs_scheme_type        scheme_out
);

    // Sequencer states; 2'b11 is unused and falls back to waiting
    typedef enum logic [1:0] {
        ST_WAIT_SUPPLY = 2'b00,
        ST_COUNT       = 2'b01,
        ST_RELEASED    = 2'b10
    } prs_state_type;

    // Sequencer state
    prs_state_type               state_reg;
    prs_state_type               state_next;

    // Delay counter and its end point
    logic [prs_pkg::CNT_W-1:0]   cnt_reg;
    logic [prs_pkg::CNT_W-1:0]   term;
    logic                        fast_reg;

    // Decoder outputs
    logic                        fast_sel;
    prs_pkg::prs_scheme_type     scheme_dec;

    // Supply summaries
    logic                        all_ok;
    logic                        run_ok;

    // Device-facing state
    logic                        cfg_reg;
    logic                        rst_out_reg;

    // Pin decoder; purely combinational, the scheme is registered below
    // and the delay class is latched while waiting
    prs_delay_sel prs_delay_sel_i (
        .scheme_select_pins (scheme_select_pins),
        .jtag_active        (jtag_active),
        .fast_sel           (fast_sel),
        .scheme             (scheme_dec)
    );

    // Supply summaries. Trip detection itself is analog and lives outside;
    // these flags arrive already filtered and synchronous to the oscillator.
    // Every supply must be good to leave power-on reset
    assign all_ok = supplies.core_ok & supplies.pll_analog_ok & supplies.io_ok;
    // Once released only core and PLL analog supply are watched
    assign run_ok = supplies.core_ok & supplies.pll_analog_ok;

    // Terminal count from the latched delay class. The counter runs from zero,
    // so the count phase lasts exactly FAST_CYC or STD_CYC oscillator cycles;
    // one more cycle is spent seeing the supplies good in the waiting state.
    assign term = fast_reg ? prs_pkg::CNT_W'(FAST_CYC - 1)
                           : prs_pkg::CNT_W'(STD_CYC - 1);

    // Next state. Any supply loss while counting restarts the whole delay;
    // after release the I/O supply is no longer watched, only core and PLL.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_WAIT_SUPPLY: begin
                // Nothing happens until all three supplies are good
                if (all_ok) begin
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                // Supply loss wins over the terminal count
                if (!all_ok) begin
                    state_next = ST_WAIT_SUPPLY;
                end else if (cnt_reg == term) begin
                    state_next = ST_RELEASED;
                end
            end
            ST_RELEASED: begin
                // I/O supply loss is ignored once released
                if (!run_ok) begin
                    state_next = ST_WAIT_SUPPLY;
                end
            end
            default: begin
                state_next = ST_WAIT_SUPPLY;
            end
        endcase
    end

    // State register; reset parks the machine in waiting, so supplies are
    // checked again from scratch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_WAIT_SUPPLY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Timing walk: edge 1 sees all supplies good and enters counting with the
    // counter at zero; the counter then steps once per edge, and the edge after
    // it reaches the terminal value moves to released and lets go of status.
    // Delay counter; restarts whenever supplies drop so a glitch cannot shorten it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= prs_pkg::CNT_RST;
        end else if (state_reg == ST_COUNT && all_ok) begin
            cnt_reg <= cnt_reg + prs_pkg::CNT_W'(1);
        end else begin
            cnt_reg <= prs_pkg::CNT_RST;
        end
    end

    // Delay class caught while waiting so a pin change mid-count is ignored.
    // The latch tracks the straps for the whole waiting phase, so a slow
    // strap still settles before the class is frozen.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fast_reg <= 1'b0;
        end else if (state_reg == ST_WAIT_SUPPLY) begin
            fast_reg <= fast_sel;
        end
    end

    // Status line: driven low until the delay ends; done line low throughout.
    // Driven from the next state so the line moves on the same edge as the
    // state, with no cycle of skew against por_active in either direction.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_n_drv <= '{o: 1'b0, oe: 1'b1};
        end else if (state_next == ST_RELEASED) begin
            status_n_drv <= '{o: 1'b0, oe: 1'b0};
        end else begin
            status_n_drv <= '{o: 1'b0, oe: 1'b1};
        end
    end

    // Done line held low until configuration data completes elsewhere.
    // Next-state based as well, so a brownout pulls it low on the very edge
    // that re-enters power-on reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conf_done_drv <= '{o: 1'b0, oe: 1'b1};
        end else if (state_next != ST_RELEASED || !cfg_reg) begin
            conf_done_drv <= '{o: 1'b0, oe: 1'b1};
        end else if (conf_done_seen) begin
            conf_done_drv <= '{o: 1'b0, oe: 1'b0};
        end
    end

    // Internal reset follows request and status line levels; it also rises on
    // the edge that leaves the released state, so a brownout resets at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_out_reg <= 1'b1;
        end else begin
            rst_out_reg <= (state_next != ST_RELEASED) | ~config_req_n | ~status_n_in;
        end
    end

    // Configuration mode once released and out of reset. It shares the reset
    // terms, so the two outputs never disagree.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= 1'b0;
        end else begin
            cfg_reg <= (state_next == ST_RELEASED) & config_req_n & status_n_in;
        end
    end

    // Scheme seen by the rest of the device; JTAG already overrides.
    // Unlike the delay class it is not frozen, since it only steers loading.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scheme_out <= prs_pkg::SCH_NONE;
        end else begin
            scheme_out <= scheme_dec;
        end
    end

    // Status outputs; por_active is decoded straight from the state register,
    // the others are flops already
    assign por_active   = (state_reg != ST_RELEASED);
    assign device_reset = rst_out_reg;
    assign config_mode  = cfg_reg;
    assign fast_delay   = fast_reg;

endmodule // prs_sequencer

// >>> prs_sequencer_properties.sv
// Port checker for the power-on-reset sequencer.
// Assumes supplies and straps are synchronous to clk.
`timescale 1ns/1ps
module prs_sequencer_properties #(
    parameter int unsigned FAST_CYC = 20,
    parameter int unsigned STD_CYC  = 50
) (
    // Clock and reset
    input wire logic                      clk,
    input wire logic                      rst_n,
    // Inputs
    input wire prs_pkg::prs_supply_type   supplies,
    input wire logic [prs_pkg::SEL_W-1:0] scheme_select_pins,
    input wire logic                      jtag_active,
    input wire logic                      config_req_n,
    input wire logic                      status_n_in,
    input wire logic                      conf_done_seen,
    // Outputs
    input wire prs_pkg::prs_od_type       status_n_drv,
    input wire prs_pkg::prs_od_type       conf_done_drv,
    input wire logic                      por_active,
    input wire logic                      device_reset,
    input wire logic                      config_mode,
    input wire logic                      fast_delay,
    input wire prs_pkg::prs_scheme_type   scheme_out
);
    logic [31:0] ok_cnt_reg;
    logic        fast_code;

    // Cycles since all supplies came good; a range allows for sampling skew
    always_ff @(posedge clk) begin
        if (!rst_n || !(&supplies))
            ok_cnt_reg <= 32'h0;
        else
            ok_cnt_reg <= ok_cnt_reg + 32'h1;
    end

    // Strap codes marked fast
    assign fast_code = scheme_select_pins inside {prs_pkg::SEL_AS_FAST, prs_pkg::SEL_AP_FAST,
                                                  prs_pkg::SEL_PS_FAST, prs_pkg::SEL_FPP};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Release of the status line, and a host that lets it stay high
    sequence release_s;
        $fell(status_n_drv.oe);
    endsequence
    sequence host_ok_s;
        config_req_n && status_n_in;
    endsequence

    supply_hold_a: assert property ((!supplies.core_ok || !supplies.pll_analog_ok
        || (por_active && !supplies.io_ok)) |=> status_n_drv.oe)
        else $error("status released without good supplies");
    por_lines_a: assert property (por_active |-> status_n_drv.oe && conf_done_drv.oe)
        else $error("lines not held low during power-on reset");
    reset_hold_a: assert property (!config_req_n || !status_n_in |=> device_reset)
        else $error("device left reset while a line was low");
    fast_delay_a: assert property (release_s ##0 fast_delay |->
        ok_cnt_reg >= FAST_CYC + 1 && ok_cnt_reg <= FAST_CYC + 3)
        else $error("fast delay length wrong");
    std_delay_a: assert property (release_s ##0 !fast_delay |->
        ok_cnt_reg >= STD_CYC + 1 && ok_cnt_reg <= STD_CYC + 3)
        else $error("standard delay length wrong");
    delay_class_a: assert property (release_s |-> fast_delay == fast_code)
        else $error("delay class does not follow straps");
    jtag_override_a: assert property (release_s ##0 jtag_active |->
        scheme_out == prs_pkg::SCH_JTAG)
        else $error("jtag did not override scheme");
    config_entry_a: assert property (release_s ##0 host_ok_s |=>
        !device_reset && config_mode)
        else $error("configuration mode not entered");
    done_release_a: assert property (host_ok_s ##0 (config_mode && conf_done_seen
        && supplies.core_ok && supplies.pll_analog_ok) |=> !conf_done_drv.oe)
        else $error("done line not released");
endmodule // prs_sequencer_properties

bind prs_sequencer prs_sequencer_properties #(.FAST_CYC(FAST_CYC), .STD_CYC(STD_CYC))
    prs_sequencer_properties_i (.clk(clk), .rst_n(rst_n), .supplies(supplies),
    .scheme_select_pins(scheme_select_pins), .jtag_active(jtag_active),
    .config_req_n(config_req_n), .status_n_in(status_n_in),
    .conf_done_seen(conf_done_seen), .status_n_drv(status_n_drv),
    .conf_done_drv(conf_done_drv), .por_active(por_active), .device_reset(device_reset),
    .config_mode(config_mode), .fast_delay(fast_delay), .scheme_out(scheme_out));

// >>> prs_host_model.sv
// Configuration host model: pulled-up status wire, request and done lines.
// Assumes bench commands change on clk edges.
`timescale 1ns/1ps
module prs_host_model (
    // Commands from the bench
    input  wire logic                req_cmd,
    input  wire logic                pull_cmd,
    input  wire logic                done_cmd,
    // Device side
    input  wire prs_pkg::prs_od_type status_n_drv,
    output logic                     config_req_n,
    output logic                     status_n_in,
    output logic                     conf_done_seen
);
    // Pull-up wins unless either party drives the wire low
    assign status_n_in = !((status_n_drv.oe && !status_n_drv.o) || pull_cmd);
    // Request held low while reconfiguration is asked for
    assign config_req_n = !req_cmd;
    assign conf_done_seen = done_cmd;
endmodule // prs_host_model

// >>> test_power_on_reset_sequencer.sv
// Testbench for the power-on-reset sequencer with a host model.
// Assumes shortened delay counts so each boot takes tens of cycles.
`timescale 1ns/1ps
module test_power_on_reset_sequencer;
    localparam int unsigned FC = 20;
    localparam int unsigned SC = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    prs_pkg::prs_supply_type sup = 3'h0;
    logic [3:0] pins = 4'h0;
    logic jtag = 1'b0;
    logic req = 1'b0;
    logic pull = 1'b0;
    logic done = 1'b0;
    prs_pkg::prs_od_type st, cd;
    prs_pkg::prs_scheme_type sch;
    logic por, dres, cmode, fast, req_n, stin, cds;
    int err_count = 0;
    int n_checks = 0;

    // 10 MHz oscillator
    always #50 clk = ~clk;

    prs_sequencer #(.FAST_CYC(FC), .STD_CYC(SC)) prs_sequencer_i (.clk(clk), .rst_n(rst_n),
        .supplies(sup), .scheme_select_pins(pins), .jtag_active(jtag), .config_req_n(req_n),
        .status_n_in(stin), .status_n_drv(st), .conf_done_drv(cd), .conf_done_seen(cds),
        .por_active(por), .device_reset(dres), .config_mode(cmode), .fast_delay(fast),
        .scheme_out(sch));
    prs_host_model prs_host_model_i (.req_cmd(req), .pull_cmd(pull), .done_cmd(done),
        .status_n_drv(st), .config_req_n(req_n), .status_n_in(stin), .conf_done_seen(cds));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Straps only change under reset, since the class is latched before counting
    task automatic do_reset(input logic [3:0] p, input logic j);
        @(posedge clk);
        rst_n <= 1'b0;
        sup <= 3'h0;
        pins <= p;
        jtag <= j;
        done <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Full boot: delay length, class, scheme, then configuration and done
    task automatic t_boot(input logic [3:0] p, input logic j, input logic f,
                          input logic [2:0] s);
        int n;
        n = 0;
        do_reset(p, j);
        @(posedge clk) sup <= 3'h7;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (st.oe === 1'b1 && n < 300);
        check(n, (f ? FC : SC) + 1);
        check(fast, f);
        check(sch, s);
        @(posedge clk);
        #1;
        check({dres, cmode}, 2'b01);
        check({por, st.o, cd.o}, 3'b000);
        @(posedge clk) done <= 1'b1;
        @(posedge clk);
        #1;
        check(cd.oe, 1'b0);
    endtask

    // Missing io supply blocks release; after release only core and PLL matter
    task automatic t_supply();
        do_reset(4'h1, 1'b0);
        @(posedge clk) sup <= 3'h6;
        repeat (FC + 10) @(posedge clk);
        #1;
        check(st.oe, 1'b1);
        @(posedge clk) sup <= 3'h7;
        repeat (FC + 3) @(posedge clk);
        @(posedge clk) sup <= 3'h6;
        repeat (3) @(posedge clk);
        #1;
        check({st.oe, dres}, 2'b00);
        @(posedge clk) sup <= 3'h5;
        @(posedge clk);
        #1;
        check(st.oe, 1'b1);
        check(por, 1'b1);
        @(posedge clk);
        #1;
        check(dres, 1'b1);
    endtask

    // Host pulls the request line, then the status line, low after release
    task automatic t_host();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) req <= (i == 0);
            pull <= (i == 1);
            @(posedge clk);
            #1;
            check(dres, 1'b1);
            @(posedge clk) req <= 1'b0;
            pull <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            check(dres, 1'b0);
        end
    endtask

    initial begin
        for (int c = 0; c < 8; c++)
            t_boot(c[3:0], 1'b0, c inside {1, 3, 5, 6}, 3'((c < 7) ? c / 2 : 5));
        t_boot(4'h1, 1'b1, 1'b1, 3'h4);
        t_boot(4'h0, 1'b1, 1'b0, 3'h4);
        t_host();
        t_supply();
        complete_run();
    end

    // Watchdog well beyond the expected five hundred or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule // test_power_on_reset_sequencer
